// file: design/pdc_device.sv
// Purpose: parameter memory and set decoder building transfer requests
// Assumes: host keeps valid high until ready; memory written before use
// Notes: one request or event handled at a time
// How it works
// - Word 1 holds source address used.
// - Word 3 holds destination address used.
// - Low half of word 2: array bytes.
// - High half of word 2: arrays per frame.
// - Word 7 low half: frames per block.
// - Source array stride added between arrays.
// - Destination array stride added between arrays.
// - Word 6 holds signed frame strides.
// - A-sync: frame stride from last array.
// - AB-sync: frame stride from first array.
// - Exhausted set copied from linked set.
// - Link of all ones means null.
// - A-sync arrays-per-frame count reloads after its last array.
// - Host should prefer whole word access.
// - Options word layout with read-only privilege.
// - A-sync: one array per event.
// - AB-sync: one frame per event.
// - Any write captures writer privilege fields.
//
// The APB register port was decided locally.
`timescale 1ns/100ps
module pdc_device (
	input  wire logic pclk,
	input  wire logic presetn,
	pdc_if.dev        link,
	output logic      busy
);
	typedef enum logic [2:0] {
		S_IDLE   = 3'b001,
		S_ISSUE  = 3'b010,
		S_UPDATE = 3'b100
	} pdc_state_t;

	pdc_state_t  state;
	pdc_state_t  next_state;
	logic [31:0] pmem [0:pdc_pkg::NSETS*8-1];
	logic [3:0]  act_set;
	logic        accept;
	logic        good;
	logic        wr_take;
	logic [31:0] ev_opt;
	logic [31:0] ev_src;
	logic [31:0] ev_cnt;
	logic [31:0] ev_dst;
	logic [31:0] ev_bidx;
	logic [31:0] ev_block_frame_count;
	logic [31:0] cu_opt;
	logic [31:0] cu_src;
	logic [31:0] cu_cnt;
	logic [31:0] cu_dst;
	logic [31:0] cu_bidx;
	logic [31:0] cu_link;
	logic [31:0] cu_cidx;
	logic [31:0] cu_block_frame_count;
	logic [31:0] src_b;
	logic [31:0] src_c;
	logic [31:0] dst_b;
	logic [31:0] dst_c;
	logic [31:0] next_src;
	logic [31:0] next_dst;
	logic [15:0] next_frame_array_count;
	logic [15:0] next_block_frame_count;
	logic        exhausted;
	logic        is_null;
	logic [3:0]  link_set;
	logic [31:0] wr_word;
	logic [31:0] wr_opt_other;
	logic [31:0] old_word;
	logic [31:0] old_opt;

	// Event set fields
	assign ev_opt  = pmem[{link.evt_set, pdc_pkg::W_OPT}];
	assign ev_src  = pmem[{link.evt_set, pdc_pkg::W_SRC}];
	assign ev_cnt  = pmem[{link.evt_set, pdc_pkg::W_CNT}];
	assign ev_dst  = pmem[{link.evt_set, pdc_pkg::W_DST}];
	assign ev_bidx = pmem[{link.evt_set, pdc_pkg::W_BIDX}];
	assign ev_block_frame_count = pmem[{link.evt_set, pdc_pkg::W_BLOCK_FRAME_COUNT}];

	// Active set fields
	assign cu_opt  = pmem[{act_set, pdc_pkg::W_OPT}];
	assign cu_src  = pmem[{act_set, pdc_pkg::W_SRC}];
	assign cu_cnt  = pmem[{act_set, pdc_pkg::W_CNT}];
	assign cu_dst  = pmem[{act_set, pdc_pkg::W_DST}];
	assign cu_bidx = pmem[{act_set, pdc_pkg::W_BIDX}];
	assign cu_link = pmem[{act_set, pdc_pkg::W_LINK}];
	assign cu_cidx = pmem[{act_set, pdc_pkg::W_CIDX}];
	assign cu_block_frame_count = pmem[{act_set, pdc_pkg::W_BLOCK_FRAME_COUNT}];

	// Set reads and writes take priority over events; both still wait while a request is issued
	assign link.req_ready = (state == S_IDLE);
	assign link.evt_ready = (state == S_IDLE) && !link.req_valid;
	assign wr_take        = (state == S_IDLE) && link.req_valid && link.req_write;
	assign accept         = (state == S_IDLE) && link.evt_valid && !link.req_valid;
	assign good = (ev_cnt[15:0] != 16'h0000) && (ev_cnt[31:16] != 16'h0000)
		&& (ev_block_frame_count[15:0] != 16'h0000);
	assign link.tr_valid = (state == S_ISSUE);
	assign busy          = (state != S_IDLE);

	pdc_stride_add u_src_b (
		.base   (cu_src),
		.stride (cu_bidx[15:0]),
		.sum    (src_b)
	);
	pdc_stride_add u_dst_b (
		.base   (cu_dst),
		.stride (cu_bidx[31:16]),
		.sum    (dst_b)
	);
	pdc_stride_add u_src_c (
		.base   (cu_src),
		.stride (cu_cidx[15:0]),
		.sum    (src_c)
	);
	pdc_stride_add u_dst_c (
		.base   (cu_dst),
		.stride (cu_cidx[31:16]),
		.sum    (dst_c)
	);

	always_comb begin
		next_src  = src_b;
		next_dst  = dst_b;
		next_frame_array_count = cu_cnt[31:16] - 16'h0001;
		next_block_frame_count = cu_block_frame_count[15:0];
		if (cu_opt[pdc_pkg::OPT_SYNC_BIT]) begin
			next_src  = src_c;
			next_dst  = dst_c;
			next_frame_array_count = cu_cnt[31:16];
			next_block_frame_count = cu_block_frame_count[15:0] - 16'h0001;
		end else if (cu_cnt[31:16] == 16'h0001) begin
			next_src  = src_c;
			next_dst  = dst_c;
			next_frame_array_count = cu_link[31:16];
			next_block_frame_count = cu_block_frame_count[15:0] - 16'h0001;
		end
	end

	assign exhausted = (next_block_frame_count == 16'h0000);
	assign is_null   = (cu_link[15:0] == pdc_pkg::NULL_LINK);
	assign link_set  = cu_link[pdc_pkg::LINK_SET_LSB +: pdc_pkg::SET_AW];

	// Half-word merge; whole-word writes avoid torn fields
	assign old_word = pmem[link.req_addr];
	assign old_opt  = pmem[{link.req_addr[6:3], pdc_pkg::W_OPT}];
	always_comb begin
		wr_word = {link.req_hen[1] ? link.req_wdata[31:16] : old_word[31:16],
			link.req_hen[0] ? link.req_wdata[15:0] : old_word[15:0]};
		if (link.req_addr[2:0] == pdc_pkg::W_OPT) begin
			wr_word = {link.req_supervisor_flag, 3'h0, link.req_master_privilege_tag,
				wr_word[pdc_pkg::OPT_WR_MSB:0]};
		end
		if (link.req_addr[2:0] == pdc_pkg::W_BLOCK_FRAME_COUNT) begin
			wr_word[31:16] = 16'h0000;
		end
		wr_opt_other = {link.req_supervisor_flag, 3'h0, link.req_master_privilege_tag,
			old_opt[pdc_pkg::OPT_WR_MSB:0]};
	end

	// Memory holds no reset; contents are undefined until programmed
	always_ff @(posedge pclk) begin
		if (wr_take) begin
			pmem[link.req_addr] <= wr_word;
			if (link.req_addr[2:0] != pdc_pkg::W_OPT) begin
				pmem[{link.req_addr[6:3], pdc_pkg::W_OPT}] <= wr_opt_other;
			end
		end else if (state == S_UPDATE) begin
			if (exhausted) begin
				for (int i = 0; i < 8; i++) begin
					if (is_null) begin
						pmem[{act_set, 3'(i)}] <= pdc_pkg::RST_WORD;
					end else begin
						pmem[{act_set, 3'(i)}] <= pmem[{link_set, 3'(i)}];
					end
				end
			end else begin
				pmem[{act_set, pdc_pkg::W_SRC}]  <= next_src;
				pmem[{act_set, pdc_pkg::W_DST}]  <= next_dst;
				pmem[{act_set, pdc_pkg::W_CNT}]  <= {next_frame_array_count, cu_cnt[15:0]};
				pmem[{act_set, pdc_pkg::W_BLOCK_FRAME_COUNT}] <= {16'h0000, next_block_frame_count};
			end
		end
	end

	always_comb begin
		next_state = state;
		case (state)
			S_IDLE: begin
				if (accept && good) begin
					next_state = S_ISSUE;
				end
			end
			S_ISSUE: begin
				if (link.tr_ready) begin
					next_state = S_UPDATE;
				end
			end
			S_UPDATE: begin
				next_state = S_IDLE;
			end
			default: begin
				next_state = S_IDLE;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= S_IDLE;
		end else begin
			state <= next_state;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			act_set      <= 4'h0;
			link.tr_src  <= pdc_pkg::RST_WORD;
			link.tr_dst  <= pdc_pkg::RST_WORD;
			link.tr_array_byte_count <= 16'h0000;
			link.tr_frame_array_count <= 16'h0000;
			link.tr_sidx <= 16'h0000;
			link.tr_didx <= 16'h0000;
			link.tr_opt  <= pdc_pkg::RST_WORD;
		end else if (accept && good) begin
			act_set      <= link.evt_set;
			link.tr_src  <= ev_src;
			link.tr_dst  <= ev_dst;
			link.tr_array_byte_count <= ev_cnt[15:0];
			link.tr_frame_array_count <= ev_opt[pdc_pkg::OPT_SYNC_BIT] ? ev_cnt[31:16] : 16'h0001;
			link.tr_sidx <= ev_bidx[15:0];
			link.tr_didx <= ev_bidx[31:16];
			link.tr_opt  <= ev_opt;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			link.rsp_valid <= 1'b0;
			link.rsp_rdata <= pdc_pkg::RST_WORD;
		end else begin
			link.rsp_valid <= (state == S_IDLE) && link.req_valid && !link.req_write;
			if ((state == S_IDLE) && link.req_valid && !link.req_write) begin
				link.rsp_rdata <= old_word;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			link.set_done  <= 1'b0;
			link.null_link <= 1'b0;
			link.evt_error <= 1'b0;
		end else begin
			link.set_done  <= (state == S_UPDATE) && exhausted;
			link.null_link <= (state == S_UPDATE) && exhausted && is_null;
			link.evt_error <= accept && !good;
		end
	end
endmodule

// file: design/pdc_host.sv
// Purpose: programming agent and request sink driven from APB registers
// Assumes: APB slave answers in the first access cycle
// Notes: a new request cannot be started while one is pending
`timescale 1ns/100ps
module pdc_host (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	output logic             irq,
	pdc_if.host              link
);
	logic [15:0]          cmd;
	logic [31:0]          wdata;
	logic [31:0]          rdata;
	logic [3:0]           evt_set;
	logic                 req_pend;
	logic                 evt_pend;
	logic [31:0]          tr_src;
	logic [31:0]          tr_dst;
	logic [31:0]          tr_cnt;
	logic [31:0]          tr_opt;
	logic [31:0]          tr_idx;
	logic [pdc_pkg::ST_W-1:0] status;
	logic [pdc_pkg::ST_W-1:0] mask;
	logic [pdc_pkg::ST_W-1:0] st_set;
	logic                 wr_en;
	logic                 mapped;
	logic                 tr_take;
	logic [31:0]          rd_mux;

	assign pready  = 1'b1;
	assign wr_en   = psel && penable && pwrite;
	assign mapped  = (paddr <= pdc_pkg::A_MASK) && (paddr[1:0] == 2'b00);
	assign pslverr = psel && penable && !mapped;
	assign irq     = |(status & mask);

	// commands carry half enables; whole words preferred
	assign link.req_valid  = req_pend;
	assign link.req_write  = cmd[pdc_pkg::CMD_WRITE_BIT];
	assign link.req_addr   = cmd[6:0];
	assign link.req_hen    = cmd[pdc_pkg::CMD_HEN_LSB +: 2];
	assign link.req_wdata  = wdata;
	assign link.req_supervisor_flag   = cmd[pdc_pkg::CMD_SUPERVISOR_FLAG_BIT];
	assign link.req_master_privilege_tag = cmd[pdc_pkg::CMD_MASTER_PRIVILEGE_TAG_LSB +: 4];
	assign link.evt_valid  = evt_pend;
	assign link.evt_set    = evt_set;
	// Uncleared transfer status bit holds off the next request so none is overwritten
	assign link.tr_ready   = !status[pdc_pkg::ST_TR];
	assign tr_take         = link.tr_valid && link.tr_ready;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cmd      <= 16'h0000;
			wdata    <= pdc_pkg::RST_WORD;
			req_pend <= 1'b0;
		end else if (wr_en && paddr == pdc_pkg::A_CMD && !req_pend) begin
			cmd      <= pwdata[15:0];
			req_pend <= 1'b1;
		end else begin
			if (wr_en && paddr == pdc_pkg::A_WDATA && !req_pend) begin
				wdata <= pwdata;
			end
			if (req_pend && link.req_ready) begin
				req_pend <= 1'b0;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			evt_set  <= 4'h0;
			evt_pend <= 1'b0;
		end else if (wr_en && paddr == pdc_pkg::A_EVENT && !evt_pend) begin
			evt_set  <= pwdata[3:0];
			evt_pend <= 1'b1;
		end else if (evt_pend && link.evt_ready) begin
			evt_pend <= 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rdata  <= pdc_pkg::RST_WORD;
			tr_src <= pdc_pkg::RST_WORD;
			tr_dst <= pdc_pkg::RST_WORD;
			tr_cnt <= pdc_pkg::RST_WORD;
			tr_opt <= pdc_pkg::RST_WORD;
			tr_idx <= pdc_pkg::RST_WORD;
		end else begin
			if (link.rsp_valid) begin
				rdata <= link.rsp_rdata;
			end
			if (tr_take) begin
				tr_src <= link.tr_src;
				tr_dst <= link.tr_dst;
				tr_cnt <= {link.tr_frame_array_count, link.tr_array_byte_count};
				tr_opt <= link.tr_opt;
				tr_idx <= {link.tr_didx, link.tr_sidx};
			end
		end
	end

	always_comb begin
		st_set = '0;
		st_set[pdc_pkg::ST_TR]   = tr_take;
		st_set[pdc_pkg::ST_CMD]  = (req_pend && link.req_ready && link.req_write)
			|| link.rsp_valid;
		st_set[pdc_pkg::ST_DONE] = link.set_done;
		st_set[pdc_pkg::ST_NULL] = link.null_link;
		st_set[pdc_pkg::ST_ERR]  = link.evt_error;
	end

	// Set beats write-one-to-clear in the same cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			status <= pdc_pkg::RST_ST;
			mask   <= pdc_pkg::RST_ST;
		end else begin
			if (wr_en && paddr == pdc_pkg::A_STATUS) begin
				status <= (status & ~pwdata[pdc_pkg::ST_W-1:0]) | st_set;
			end else begin
				status <= status | st_set;
			end
			if (wr_en && paddr == pdc_pkg::A_MASK) begin
				mask <= pwdata[pdc_pkg::ST_W-1:0];
			end
		end
	end

	always_comb begin
		rd_mux = pdc_pkg::RST_WORD;
		case (paddr)
			pdc_pkg::A_CMD:    rd_mux = {req_pend, 15'h0000, cmd};
			pdc_pkg::A_WDATA:  rd_mux = wdata;
			pdc_pkg::A_RDATA:  rd_mux = rdata;
			pdc_pkg::A_EVENT:  rd_mux = {evt_pend, 27'h0000000, evt_set};
			pdc_pkg::A_TR_SRC: rd_mux = tr_src;
			pdc_pkg::A_TR_DST: rd_mux = tr_dst;
			pdc_pkg::A_TR_CNT: rd_mux = tr_cnt;
			pdc_pkg::A_TR_OPT: rd_mux = tr_opt;
			pdc_pkg::A_TR_IDX: rd_mux = tr_idx;
			pdc_pkg::A_STATUS: rd_mux = {27'h0000000, status};
			pdc_pkg::A_MASK:   rd_mux = {27'h0000000, mask};
			default:           rd_mux = pdc_pkg::RST_WORD;
		endcase
	end

	// Read data latched in the setup cycle, stable through the access cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= pdc_pkg::RST_WORD;
		end else if (psel && !penable) begin
			prdata <= rd_mux;
		end
	end
endmodule

// file: design/pdc_stride_add.sv
// Purpose: byte address plus signed 16-bit stride
// Assumes: wrap-around at 32 bits
// Notes: used for array and frame steps
`timescale 1ns/100ps
module pdc_stride_add (
	input  wire logic [31:0] base,
	input  wire logic [15:0] stride,
	output logic      [31:0] sum
);
	// Sign extension keeps negative strides stepping backward
	assign sum = base + {{16{stride[15]}}, stride};
endmodule

// file: inc/pdc_if.sv
// Purpose: link between the parameter set decoder and its host
// Assumes: both ends on pclk
// Notes: handshakes are valid/ready, a transfer happens when both are high
`timescale 1ns/100ps
interface pdc_if;
	logic        req_valid;
	logic        req_ready;
	logic        req_write;
	logic [6:0]  req_addr;
	logic [1:0]  req_hen;
	logic [31:0] req_wdata;
	logic        req_supervisor_flag;
	logic [3:0]  req_master_privilege_tag;
	logic        rsp_valid;
	logic [31:0] rsp_rdata;
	logic        evt_valid;
	logic        evt_ready;
	logic [3:0]  evt_set;
	logic        tr_valid;
	logic        tr_ready;
	logic [31:0] tr_src;
	logic [31:0] tr_dst;
	logic [15:0] tr_array_byte_count;
	logic [15:0] tr_frame_array_count;
	logic [15:0] tr_sidx;
	logic [15:0] tr_didx;
	logic [31:0] tr_opt;
	logic        set_done;
	logic        null_link;
	logic        evt_error;

	modport dev (
		input  req_valid, req_write, req_addr, req_hen, req_wdata, req_supervisor_flag, req_master_privilege_tag,
		output req_ready, rsp_valid, rsp_rdata,
		input  evt_valid, evt_set,
		output evt_ready,
		output tr_valid, tr_src, tr_dst, tr_array_byte_count, tr_frame_array_count, tr_sidx, tr_didx, tr_opt,
		input  tr_ready,
		output set_done, null_link, evt_error
	);
	modport host (
		output req_valid, req_write, req_addr, req_hen, req_wdata, req_supervisor_flag, req_master_privilege_tag,
		input  req_ready, rsp_valid, rsp_rdata,
		output evt_valid, evt_set,
		input  evt_ready,
		input  tr_valid, tr_src, tr_dst, tr_array_byte_count, tr_frame_array_count, tr_sidx, tr_didx, tr_opt,
		output tr_ready,
		input  set_done, null_link, evt_error
	);
endinterface

// file: inc/pdc_pkg.sv
// Purpose: shared constants for the parameter set decoder and its host
// Assumes: one parameter memory of NSETS eight-word sets, 32-bit words
// Notes: widths fixed; no imports, every use is scoped
package pdc_pkg;
	localparam int NSETS   = 16;
	localparam int SET_AW  = 4;
	localparam int WORD_AW = 3;
	localparam int ADDR_W  = 7;

	// Word indices inside one parameter set (byte offset / 4)
	localparam logic [2:0] W_OPT  = 3'h0;
	localparam logic [2:0] W_SRC  = 3'h1;
	localparam logic [2:0] W_CNT  = 3'h2;
	localparam logic [2:0] W_DST  = 3'h3;
	localparam logic [2:0] W_BIDX = 3'h4;
	localparam logic [2:0] W_LINK = 3'h5;
	localparam logic [2:0] W_CIDX = 3'h6;
	localparam logic [2:0] W_BLOCK_FRAME_COUNT = 3'h7;

	// Channel options word fields
	localparam int OPT_SUPERVISOR_FLAG_BIT   = 31;
	localparam int OPT_MASTER_PRIVILEGE_TAG_LSB = 24;
	localparam int OPT_WR_MSB     = 23;
	localparam int OPT_SYNC_BIT   = 2;

	localparam logic [15:0] NULL_LINK    = 16'hFFFF;
	localparam int          LINK_SET_LSB = 5;

	// Host register offsets (APB byte addresses)
	localparam logic [7:0] A_CMD    = 8'h00;
	localparam logic [7:0] A_WDATA  = 8'h04;
	localparam logic [7:0] A_RDATA  = 8'h08;
	localparam logic [7:0] A_EVENT  = 8'h0C;
	localparam logic [7:0] A_TR_SRC = 8'h10;
	localparam logic [7:0] A_TR_DST = 8'h14;
	localparam logic [7:0] A_TR_CNT = 8'h18;
	localparam logic [7:0] A_TR_OPT = 8'h1C;
	localparam logic [7:0] A_TR_IDX = 8'h20;
	localparam logic [7:0] A_STATUS = 8'h24;
	localparam logic [7:0] A_MASK   = 8'h28;

	// Command word fields
	localparam int CMD_WRITE_BIT  = 8;
	localparam int CMD_HEN_LSB    = 9;
	localparam int CMD_SUPERVISOR_FLAG_BIT   = 11;
	localparam int CMD_MASTER_PRIVILEGE_TAG_LSB = 12;
	localparam int CMD_BUSY_BIT   = 31;

	// Status and mask bits
	localparam int ST_W    = 5;
	localparam int ST_TR   = 0;
	localparam int ST_CMD  = 1;
	localparam int ST_DONE = 2;
	localparam int ST_NULL = 3;
	localparam int ST_ERR  = 4;

	localparam logic [31:0] RST_WORD = 32'h0000_0000;
	localparam logic [4:0]  RST_ST   = 5'h00;
endpackage

// file: sim/pdc_assertions.sv
// Purpose: concurrent checks on the link between decoder and host
// Assumes: one pclk domain; presetn low resets both ends
// Notes: sees interface signals only; set contents are judged by the bench
`timescale 1ns/100ps
module pdc_assertions (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        req_valid,
	input wire logic        req_ready,
	input wire logic        req_write,
	input wire logic        rsp_valid,
	input wire logic        evt_valid,
	input wire logic        evt_ready,
	input wire logic        tr_valid,
	input wire logic        tr_ready,
	input wire logic [31:0] tr_src,
	input wire logic [31:0] tr_dst,
	input wire logic [15:0] tr_frame_array_count,
	input wire logic [31:0] tr_opt,
	input wire logic        set_done,
	input wire logic        null_link,
	input wire logic        evt_error
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	tr_hold_a: assert property (tr_valid && !tr_ready |=>
		tr_valid && $stable(tr_src) && $stable(tr_dst) && $stable(tr_opt))
		else $error("stalled request changed");
	a_sync_one_a: assert property (tr_valid && !tr_opt[2] |-> tr_frame_array_count == 16'h0001)
		else $error("array-sync request not one array");
	ab_frame_a: assert property (tr_valid && tr_opt[2] |-> tr_frame_array_count != 16'h0000)
		else $error("frame request with no arrays");
	opt_rsvd_a: assert property (tr_valid |-> tr_opt[30:28] == 3'h0)
		else $error("reserved option bits set");
	one_tr_a: assert property (tr_valid && tr_ready |=> !tr_valid [*2])
		else $error("second request for one event");
	evt_gap_a: assert property (evt_valid && evt_ready |=> !(evt_valid && evt_ready) [*2])
		else $error("events accepted too close");
	evt_answer_a: assert property (evt_valid && evt_ready |=> ##[0:1] (tr_valid || evt_error))
		else $error("event neither issued nor refused");
	null_done_a: assert property (null_link |-> set_done)
		else $error("null link without exhaustion");
	done_after_tr_a: assert property (set_done |-> $past(tr_valid, 2) && $past(tr_ready, 2))
		else $error("exhaustion not after last request");
	write_wins_a: assert property (req_valid |-> !evt_ready)
		else $error("event taken beside a set access");
	busy_refuse_a: assert property (tr_valid |-> !req_ready && !evt_ready)
		else $error("access taken while issuing");
	read_answer_a: assert property (req_valid && req_ready && !req_write |=> rsp_valid)
		else $error("read not answered next cycle");
	err_no_tr_a: assert property (evt_error |-> !tr_valid)
		else $error("refused event still issued");

	cover property (tr_valid && tr_ready && tr_opt[2]);
	cover property (tr_valid && tr_ready && !tr_opt[2]);
	cover property (set_done && !null_link);
	cover property (null_link);
	cover property (evt_error);
endmodule

// file: sim/tb_top.sv
// Purpose: self-checking bench for decoder and host joined by their interface
// Assumes: APB changed just after rising edges; link results watched at falling edges
// Notes: play models the address walk; a stalled request is provoked on purpose
`timescale 1ns/100ps
module tb_top;
	typedef struct {logic [31:0] src, dst, channel_options_word; logic [15:0] array_byte_count, frame_array_count, sidx, didx;} pdc_tr_t;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, busy;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rv;
	logic [31:0] ex[4][8];
	pdc_tr_t     tq[$];
	pdc_tr_t     t;
	logic [31:0] rq[$];
	integer      seed = 32'h1859;
	int          bad_count = 0;
	int          checks_done = 0;

	pdc_if link();
	pdc_device i_pdc_device (.pclk(pclk), .presetn(presetn), .link(link), .busy(busy));
	pdc_host i_pdc_host (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .irq(irq), .link(link));
	pdc_assertions i_pdc_assertions (.pclk(pclk), .presetn(presetn),
		.req_valid(link.req_valid), .req_ready(link.req_ready), .req_write(link.req_write),
		.rsp_valid(link.rsp_valid), .evt_valid(link.evt_valid), .evt_ready(link.evt_ready),
		.tr_valid(link.tr_valid), .tr_ready(link.tr_ready), .tr_src(link.tr_src),
		.tr_dst(link.tr_dst), .tr_frame_array_count(link.tr_frame_array_count), .tr_opt(link.tr_opt),
		.set_done(link.set_done), .null_link(link.null_link), .evt_error(link.evt_error));

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		checks_done++;
		if (s !== e) begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", nm, e, s);
		end
	endtask

	function automatic logic [31:0] sx(input logic [15:0] v);
		return {{16{v[15]}}, v};
	endfunction

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n = 0;
		psel    <= 1'b1;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rv = prdata;
		chk("pready", 32'h1, {31'h0, pready});
		chk("pslverr", {31'h0, a > 8'h28 || a[1:0] != 2'h0}, {31'h0, pslverr});
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	// Polls one status bit; a transfer bit is left set so the next request stalls
	task automatic waitst(input int b);
		int n = 0;
		do begin
			apb(1'b0, pdc_pkg::A_STATUS, 32'h0);
			n++;
		end while (rv[b] !== 1'b1 && n < 50);
		chk("status bit", 32'h1, {31'h0, rv[b]});
		if (b != pdc_pkg::ST_TR)
			apb(1'b1, pdc_pkg::A_STATUS, 32'h1 << b);
	endtask

	task automatic pw(input int s, input int w, input logic [31:0] d, input logic [1:0] he,
		input logic pv, input logic [3:0] id);
		apb(1'b1, pdc_pkg::A_WDATA, d);
		apb(1'b1, pdc_pkg::A_CMD, {16'h0, id, pv, he, 1'b1, 1'b0, s[3:0], w[2:0]});
		waitst(pdc_pkg::ST_CMD);
		for (int i = 0; i < 2; i++)
			if (he[i]) ex[s][w][16*i +: 16] = d[16*i +: 16];
		ex[s][0][31:24] = {pv, 3'h0, id};
		if (w == 7) ex[s][7][31:16] = 16'h0;
	endtask

	task automatic rd(input int s, input int w);
		rq.push_back(ex[s][w]);
		apb(1'b1, pdc_pkg::A_CMD, {24'h0, 1'b0, s[3:0], w[2:0]});
		waitst(pdc_pkg::ST_CMD);
		apb(1'b0, pdc_pkg::A_RDATA, 32'h0);
		chk("rdata", ex[s][w], rv);
	endtask

	task automatic prog(input int s, input logic sy, input logic [15:0] b, c, r, lk);
		logic [31:0] d[8];
		for (int i = 0; i < 8; i++) d[i] = $random(seed);
		d[0][2] = sy;
		d[2] = {b, d[2][15:0] | 16'h1};
		d[5] = {r, lk};
		d[7][15:0] = c;
		for (int i = 0; i < 8; i++) pw(s, i, d[i], 2'h3, 1'b1, 4'h5);
	endtask

	task automatic fire(input int s, input int b);
		logic [31:0] pre;
		apb(1'b0, pdc_pkg::A_STATUS, 32'h0);
		pre = rv;
		apb(1'b1, pdc_pkg::A_EVENT, {28'h0, s[3:0]});
		// Clearing a stale transfer bit only now holds the new request for a few cycles
		if (pre[pdc_pkg::ST_TR])
			apb(1'b1, pdc_pkg::A_STATUS, 32'h1 << pdc_pkg::ST_TR);
		waitst(b);
	endtask

	// Walks set s with the expected contents of set f; ends with the link reload
	task automatic play(input int s, input int f);
		logic [31:0] cs, cd, e[8];
		logic [15:0] b, c;
		e = ex[f];
		cs = e[1];
		cd = e[3];
		b = e[2][31:16];
		c = e[7][15:0];
		while (c != 16'h0) begin
			tq.push_back('{cs, cd, e[0], e[2][15:0], e[0][2] ? b : 16'h1, e[4][15:0], e[4][31:16]});
			fire(s, pdc_pkg::ST_TR);
			apb(1'b0, pdc_pkg::A_TR_SRC, 32'h0);
			chk("tr_src reg", cs, rv);
			if (e[0][2] || b == 16'h1) begin
				cs = cs + sx(e[6][15:0]);
				cd = cd + sx(e[6][31:16]);
				b = e[0][2] ? b : e[5][31:16];
				c--;
			end else begin
				cs = cs + sx(e[4][15:0]);
				cd = cd + sx(e[4][31:16]);
				b--;
			end
		end
		if (e[5][15:0] == pdc_pkg::NULL_LINK)
			ex[s] = '{default: 32'h0};
		else
			ex[s] = ex[e[5][8:5]];
	endtask

	task automatic stat(input logic [31:0] e);
		apb(1'b0, pdc_pkg::A_STATUS, 32'h0);
		chk("status", e, rv);
		apb(1'b1, pdc_pkg::A_STATUS, 32'h1F);
	endtask

	task automatic summarize();
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	always @(negedge pclk) begin
		if (link.tr_valid === 1'b1 && link.tr_ready === 1'b1) begin
			if (tq.size() != 0)
				t = tq.pop_front();
			else
				t = '{default: 'x};
			chk("tr_src", t.src, link.tr_src);
			chk("tr_dst", t.dst, link.tr_dst);
			chk("tr_array_byte_count", 32'(t.array_byte_count), 32'(link.tr_array_byte_count));
			chk("tr_frame_array_count", 32'(t.frame_array_count), 32'(link.tr_frame_array_count));
			chk("tr_sidx", 32'(t.sidx), 32'(link.tr_sidx));
			chk("tr_didx", 32'(t.didx), 32'(link.tr_didx));
			chk("tr_opt", t.channel_options_word, link.tr_opt);
		end
		if (link.rsp_valid === 1'b1)
			chk("rsp_rdata", rq.size() != 0 ? rq.pop_front() : 'x, link.rsp_rdata);
	end

	initial begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end

	initial begin
		repeat (20000) @(posedge pclk);
		bad_count++;
		summarize();
	end

	initial begin
		presetn = 1'b0;
		psel    = 1'b0;
		penable = 1'b0;
		pwrite  = 1'b0;
		paddr   = 8'h00;
		pwdata  = 32'h0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		for (int a = 0; a <= 46; a += 2) begin
			apb(1'b0, a[7:0], 32'h0);
			chk("reset value", pdc_pkg::RST_WORD, rv);
		end
		apb(1'b1, pdc_pkg::A_MASK, 32'h1 << pdc_pkg::ST_DONE);
		prog(0, 1'b0, 16'h2, 16'h2, 16'h3, pdc_pkg::NULL_LINK);
		pw(0, 3, $random(seed), 2'h1, 1'b1, 4'h5);
		pw(0, 1, $random(seed), 2'h2, 1'b1, 4'h5);
		pw(0, 7, 32'hFFFF_0002, 2'h3, 1'b0, 4'h9);
		rd(0, 0);
		rd(0, 7);
		rd(0, 3);
		play(0, 0);
		chk("irq", 32'h1, {31'h0, irq});
		apb(1'b1, pdc_pkg::A_MASK, 32'h0);
		chk("irq masked", 32'h0, {31'h0, irq});
		stat(32'h0D);
		fire(0, pdc_pkg::ST_ERR);
		prog(2, 1'b0, 16'h2, 16'h1, 16'h1, pdc_pkg::NULL_LINK);
		prog(1, 1'b1, 16'h3, 16'h2, 16'h0, 16'h0040);
		play(1, 1);
		stat(32'h05);
		play(1, 1);
		stat(32'h0D);
		rd(1, 2);
		chk("queues", 32'h0, 32'(tq.size() + rq.size()));
		chk("busy", 32'h0, {31'h0, busy});
		summarize();
	end
endmodule
